/* File: pg_fault_pkg.sv */
// Shared constants and types for the power-good and fault status block
package pg_fault_pkg;

	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] PG_SELECT_ADDR  = 8'h0B;
	localparam logic [7:0] LATCHOFF_ADDR   = 8'h0C;
	localparam logic [7:0] LIVE_PG_ADDR    = 8'h0D;
	localparam logic [7:0] EVENT_ADDR      = 8'h0E;

	// ------------------------------------------------------------------
	// Field layout and widths
	// ------------------------------------------------------------------
	localparam int NUM_CH          = 4;
	localparam int LATCH_W         = 5;
	localparam int EVENT_W         = 6;
	localparam int LATCH_TSD_BIT   = 4;
	localparam int EVENT_HOT_BIT   = 5;
	localparam int EVENT_LOW_BIT   = 4;
	localparam logic [1:0] HOT_DISABLED = 2'h0;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [3:0] SELECT_RST = 4'h0;
	localparam logic [7:0] RDATA_RST  = 8'h00;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_FREQ_KHZ     = 10000;
	localparam int VALID_DELAY_US   = 1000;
	localparam int VALID_DELAY_CYC  = (VALID_DELAY_US * CLK_FREQ_KHZ + 999)
		/ 1000;

	// ------------------------------------------------------------------
	// Register port carrier
	// ------------------------------------------------------------------
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

endpackage : pg_fault_pkg

/* File: sticky_flags.sv */
// Vector of sticky flags, set by hardware and cleared by request
`timescale 1ns/1ps
module sticky_flags #(
	parameter int W = 4
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_set,
	input  wire logic [W-1:0] i_clr,
	output logic      [W-1:0] o_flags
);
	logic [W-1:0] flags_reg;
	logic [W-1:0] flags_next;

	// Set wins over a clear arriving in the same cycle
	always_comb begin
		flags_next = i_set | (flags_reg & ~i_clr);
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			flags_reg <= '0;
		end else begin
			flags_reg <= flags_next;
		end
	end

	assign o_flags = flags_reg;
endmodule : sticky_flags

/* File: ok_validate.sv */
// Rising-edge qualifier: output rises only after a held condition
`timescale 1ns/1ps
module ok_validate #(
	parameter int DELAY_CYCLES = 10000
) (
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_cond,
	output logic      o_ok
);
	typedef enum logic [1:0] {
		ST_LOW  = 2'b00,
		ST_WAIT = 2'b01,
		ST_GOOD = 2'b11
	} val_state_e;

	val_state_e  state_reg;
	val_state_e  state_next;
	logic [31:0] cnt_reg;
	logic [31:0] cnt_next;
	logic        ok_reg;
	logic        ok_next;

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		ok_next    = 1'b0;
		unique case (state_reg)
			ST_LOW: begin
				cnt_next = 32'h1;
				if (i_cond) begin
					state_next = ST_WAIT;
				end
			end
			ST_WAIT: begin
				cnt_next = cnt_reg + 32'h1;
				if (!i_cond) begin
					state_next = ST_LOW;
				end else if (cnt_reg >= 32'(DELAY_CYCLES)) begin
					state_next = ST_GOOD;
					ok_next    = 1'b1;
				end
			end
			ST_GOOD: begin
				if (i_cond) begin
					ok_next = 1'b1;
				end else begin
					state_next = ST_LOW;
				end
			end
			default: begin
				state_next = ST_LOW;
			end
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_reg <= ST_LOW;
			cnt_reg   <= 32'h0;
			ok_reg    <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			ok_reg    <= ok_next;
		end
	end

	assign o_ok = ok_reg;
endmodule : ok_validate

/* File: power_good_fault_status.sv */
// Power-good combiner, latch-off flags and event flags with interrupt pin
// Functional notes
// RL1 - Combined ok output is AND of all included channel ok signals.
// RL2 - Combined ok output rises only after condition held one millisecond.
// RL3 - Select bits 3..0 include channels 4..1; one includes, zero excludes.
// RL4 - Select power-up value comes from one fuse level for all channels.
// RL5 - Latch-off bit 4 records a thermal shutdown.
// RL6 - Latch-off bits 3..0 record channel short or overvoltage latch-off.
// RL7 - Latch-off flags stay set; write one clears only if fault gone.
// RL8 - Readback bits 3..0 show live channel ok levels.
// RL9 - Event bit 5 sets when junction temperature exceeds threshold.
// RL10 - Event bit 4 sets when input supply falls below threshold.
// RL11 - Event bits 3..0 set on channel power-good failure.
// RL12 - Interrupt pin low while any allowed event flag is set.
// RL13 - Event flags stay set; cleared by write one or all enables low.
// RL14 - Channel failure events are not recorded during init or shutdown.
// RL15 - Event mask bit one lets event drive pin; overheat at bit 5.
// RL16 - Overheat flag never raised while threshold select is code zero.
// RL17 - Clear write during active fault leaves flag set.
`timescale 1ns/1ps
module power_good_fault_status #(
	parameter int VALID_DELAY_CYCLES = pg_fault_pkg::VALID_DELAY_CYC
) (
	input  wire logic                  i_clk,
	input  wire logic                  i_rst,
	input  wire pg_fault_pkg::reg_req_s i_reg,
	output logic [7:0]                 o_reg_rdata,
	input  wire logic [3:0]            i_ch_ok_live,
	input  wire logic                  i_fuse_ok_include,
	input  wire logic                  i_thermal_shutdown,
	input  wire logic [3:0]            i_latchoff_fault,
	input  wire logic                  i_overheat,
	input  wire logic [1:0]            i_overheat_threshold_sel,
	input  wire logic                  i_low_supply,
	input  wire logic [3:0]            i_channel_enable_pins,
	input  wire logic                  i_pg_event_hold,
	input  wire logic [5:0]            i_event_mask,
	output logic                       o_combined_supply_ok_out,
	output logic                       o_int_n
);
	// ------------------------------------------------------------------
	// Channel select register
	// ------------------------------------------------------------------
	logic [3:0] select_reg;
	logic [3:0] select_next;
	logic       fuse_loaded_reg;
	logic       fuse_loaded_next;
	logic       sel_wr;

	assign sel_wr = i_reg.wr && (i_reg.addr == pg_fault_pkg::PG_SELECT_ADDR);

	// Fuse level is sampled by the first clock after release, not by reset
	always_comb begin
		fuse_loaded_next = 1'b1;
		select_next      = select_reg;
		if (!fuse_loaded_reg) begin
			select_next = {4{i_fuse_ok_include}}; // [RL4]
		end else if (sel_wr) begin
			select_next = i_reg.wdata[3:0]; // [RL3]
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			select_reg      <= pg_fault_pkg::SELECT_RST;
			fuse_loaded_reg <= 1'b0;
		end else begin
			select_reg      <= select_next;
			fuse_loaded_reg <= fuse_loaded_next;
		end
	end

	// ------------------------------------------------------------------
	// Combined ok output
	// ------------------------------------------------------------------
	logic ok_cond;

	assign ok_cond = &(i_ch_ok_live | ~select_reg); // [RL1] [RL3]

	ok_validate #(
		.DELAY_CYCLES (VALID_DELAY_CYCLES)
	) u_validate (
		.i_clk  (i_clk),
		.i_rst  (i_rst),
		.i_cond (ok_cond), // [RL2]
		.o_ok   (o_combined_supply_ok_out)
	);

	// ------------------------------------------------------------------
	// Latch-off flags
	// ------------------------------------------------------------------
	logic [4:0] latch_set;
	logic [4:0] latch_clr;
	logic [4:0] latch_flags;
	logic       latch_wr;

	assign latch_wr = i_reg.wr && (i_reg.addr == pg_fault_pkg::LATCHOFF_ADDR);

	// Fault levels keep setting, so a clear cannot win while one persists
	assign latch_set = {i_thermal_shutdown, i_latchoff_fault}; // [RL5] [RL6]
	assign latch_clr = latch_wr ? i_reg.wdata[4:0] & ~latch_set :
		5'h00; // [RL7] [RL17]

	sticky_flags #(
		.W (pg_fault_pkg::LATCH_W)
	) u_latch (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_set   (latch_set),
		.i_clr   (latch_clr),
		.o_flags (latch_flags)
	);

	// ------------------------------------------------------------------
	// Event flags
	// ------------------------------------------------------------------
	logic [3:0] ok_prev_reg;
	logic [3:0] ok_prev_next;
	logic [3:0] pg_fail;
	logic       hot_set;
	logic [5:0] event_set;
	logic [5:0] event_clr;
	logic [5:0] event_flags;
	logic       all_disabled;
	logic       event_wr;

	// Previous level resets low, so a channel bad at release is not flagged
	always_comb begin
		ok_prev_next = i_ch_ok_live;
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ok_prev_reg <= 4'h0;
		end else begin
			ok_prev_reg <= ok_prev_next;
		end
	end

	// Failure is a fall of a channel ok level outside init or shutdown
	assign pg_fail = (ok_prev_reg & ~i_ch_ok_live) &
		{4{!i_pg_event_hold}}; // [RL11] [RL14]
	assign hot_set = i_overheat &&
		(i_overheat_threshold_sel != pg_fault_pkg::HOT_DISABLED); // [RL9] [RL16]
	assign event_set = {hot_set, i_low_supply, pg_fail}; // [RL10]
	assign all_disabled = (i_channel_enable_pins == 4'h0);
	assign event_wr = i_reg.wr && (i_reg.addr == pg_fault_pkg::EVENT_ADDR);
	assign event_clr = (all_disabled ? 6'h3F : 6'h00) |
		(event_wr ? i_reg.wdata[5:0] : 6'h00); // [RL13]

	sticky_flags #(
		.W (pg_fault_pkg::EVENT_W)
	) u_event (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_set   (event_set), // [RL17]
		.i_clr   (event_clr),
		.o_flags (event_flags)
	);

	// ------------------------------------------------------------------
	// Interrupt pin and read data
	// ------------------------------------------------------------------
	logic       int_n_reg;
	logic       int_n_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;

	// Registered pin: a glitch on mask or flags cannot pulse it
	always_comb begin
		int_n_next = ~|(event_flags & i_event_mask); // [RL12] [RL15]
		rdata_next = rdata_reg;
		if (i_reg.rd) begin
			unique case (i_reg.addr)
				pg_fault_pkg::PG_SELECT_ADDR: rdata_next = {4'h0, select_reg};
				pg_fault_pkg::LATCHOFF_ADDR:  rdata_next = {3'h0, latch_flags};
				pg_fault_pkg::LIVE_PG_ADDR: begin
					rdata_next = {4'h0, i_ch_ok_live}; // [RL8]
				end
				pg_fault_pkg::EVENT_ADDR:     rdata_next = {2'h0, event_flags};
				default:                      rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			int_n_reg <= 1'b1;
			rdata_reg <= pg_fault_pkg::RDATA_RST;
		end else begin
			int_n_reg <= int_n_next;
			rdata_reg <= rdata_next;
		end
	end

	assign o_int_n     = int_n_reg;
	assign o_reg_rdata = rdata_reg;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	// Helper: consecutive cycles the ok condition has held
	logic [31:0] held_cnt_reg;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			held_cnt_reg <= 32'h0;
		end else if (!ok_cond) begin
			held_cnt_reg <= 32'h0;
		end else if (held_cnt_reg != 32'hFFFFFFFF) begin
			held_cnt_reg <= held_cnt_reg + 32'h1;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	comb_low_a: assert property (!ok_cond |=> !o_combined_supply_ok_out) // [RL1]
		else $error("combined ok high with an included channel low");
	rise_delay_a: assert property ($rose(o_combined_supply_ok_out) |->
		held_cnt_reg >= 32'(VALID_DELAY_CYCLES)) // [RL2]
		else $error("combined ok rose before validation delay");
	select_all_a: assert property (select_reg == 4'hF && !(&i_ch_ok_live)
		|=> !o_combined_supply_ok_out) // [RL3]
		else $error("fully selected mask ignored a low channel");
	fuse_load_a: assert property ($rose(fuse_loaded_reg) |->
		select_reg == {4{$past(i_fuse_ok_include)}}) // [RL4]
		else $error("select did not load fuse level");
	select_wr_a: assert property (sel_wr && fuse_loaded_reg
		|=> select_reg == $past(i_reg.wdata[3:0])) // [RL3]
		else $error("select write not taken");
	select_hold_a: assert property (fuse_loaded_reg && !sel_wr
		|=> $stable(select_reg)) // [RL3]
		else $error("select changed without a write");

	tsd_set_a: assert property (i_thermal_shutdown |=> latch_flags[4]) // [RL5]
		else $error("thermal shutdown not recorded");
	latch_set_a: assert property (i_latchoff_fault[3] |=> latch_flags[3]) // [RL6]
		else $error("channel latch-off not recorded");
	latch_hold_a: assert property (latch_flags[0] && i_latchoff_fault[0]
		|=> latch_flags[0] [*2] or ##1 !i_latchoff_fault[0]) // [RL7]
		else $error("latch-off flag lost while fault present");
	latch_clr_a: assert property (latch_wr && i_reg.wdata[0] &&
		!i_latchoff_fault[0] |=> !latch_flags[0]) // [RL7]
		else $error("latch-off flag not cleared by write");
	latch_keep_a: assert property (latch_flags[4] && !latch_wr
		|=> latch_flags[4]) // [RL7]
		else $error("latch-off flag dropped without a write");
	latch_race_a: assert property (latch_wr && i_reg.wdata[0] &&
		i_latchoff_fault[0] |=> latch_flags[0]) // [RL17]
		else $error("latch-off flag cleared while fault present");

	live_read_a: assert property (i_reg.rd &&
		i_reg.addr == pg_fault_pkg::LIVE_PG_ADDR
		|=> o_reg_rdata == {4'h0, $past(i_ch_ok_live)}) // [RL8]
		else $error("live readback mismatch");
	rsvd_read_a: assert property (i_reg.rd
		|=> o_reg_rdata[7:6] == 2'h0) // [RL8]
		else $error("reserved read bits not zero");
	hot_set_a: assert property (i_overheat &&
		i_overheat_threshold_sel != pg_fault_pkg::HOT_DISABLED
		|=> event_flags[5]) // [RL9]
		else $error("overheat flag not set");
	low_set_a: assert property (i_low_supply |=> event_flags[4]) // [RL10]
		else $error("low supply flag not set");
	pg_fail_a: assert property (i_ch_ok_live[2] ##1 !i_ch_ok_live[2] &&
		!i_pg_event_hold |=> event_flags[2]) // [RL11]
		else $error("power-good failure not recorded");
	event_clr_a: assert property (event_wr && i_reg.wdata[5] &&
		!i_overheat |=> !event_flags[5]) // [RL13]
		else $error("overheat flag not cleared by write");
	event_keep_a: assert property (event_flags[2] && !event_wr &&
		!all_disabled |=> event_flags[2]) // [RL13]
		else $error("failure flag dropped without a clear");

	int_pin_a: assert property (|(event_flags & i_event_mask)
		|=> !o_int_n) // [RL12]
		else $error("interrupt pin not asserted");
	int_masked_a: assert property (!(|(event_flags & i_event_mask))
		|=> o_int_n) // [RL15]
		else $error("masked event drove interrupt pin");
	en_clear_a: assert property (all_disabled && !(|event_set)
		|=> event_flags == 6'h00) // [RL13]
		else $error("flags not cleared with all enables low");
	hold_ok_a: assert property (!event_flags[0] && i_pg_event_hold
		|=> !event_flags[0]) // [RL14]
		else $error("failure recorded during init or shutdown");
	hot_off_a: assert property (!event_flags[5] &&
		i_overheat_threshold_sel == 2'h0 |=> !event_flags[5]) // [RL16]
		else $error("overheat raised while disabled");
	clear_race_a: assert property (event_wr && i_low_supply
		|=> event_flags[4]) // [RL17]
		else $error("active event cleared by write");

	// ------------------------------------------------------------------
	// Cover properties
	// ------------------------------------------------------------------
	ok_rise_c: cover property ($rose(o_combined_supply_ok_out));
	int_fire_c: cover property ($fell(o_int_n));
	latch_clr_c: cover property ($fell(latch_flags[3]));
	en_clr_c: cover property (all_disabled && |event_flags);
	clear_race_c: cover property (event_wr && i_low_supply);
endmodule : power_good_fault_status

/* File: reg_host.sv */
// Host model driving the block's parallel register request port
`timescale 1ns/1ps
module reg_host (
	input  wire logic             i_clk,
	input  wire logic [7:0]       i_rdata,
	output pg_fault_pkg::reg_req_s o_req
);
	// ------------------------------------------------------------------
	// Idle request
	// ------------------------------------------------------------------
	initial o_req = '0;

	// ------------------------------------------------------------------
	// Access tasks; each ends on a rising edge
	// ------------------------------------------------------------------
	// Single-cycle write strobe; a one in a flag bit asks for its clear
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge i_clk);
		o_req <= '0;
	endtask : wr

	// Read data is registered at the taking edge, so sample just after it
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_clk);
		o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge i_clk);
		o_req <= '0;
		#1 d = i_rdata;
		@(posedge i_clk);
	endtask : rd
endmodule : reg_host

/* File: testbench.sv */
// Self-checking bench for the power-good and fault status block
`timescale 1ns/1ps
module testbench;
	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	logic                   i_clk = 1'b0;
	logic                   i_rst;
	pg_fault_pkg::reg_req_s req;
	logic [7:0]             rdata;
	logic [3:0]             live, latch, en;
	logic                   fuse, tsd, hot, low, hold, ok, int_n;
	logic [1:0]             sel;
	logic [5:0]             mask;
	int                     n_errors = 0;
	int                     compares = 0;

	always #50 i_clk = ~i_clk;

	// Short validation delay keeps the run brief
	power_good_fault_status #(
		.VALID_DELAY_CYCLES(8)
	) u_power_good_fault_status (
		.i_clk(i_clk), .i_rst(i_rst), .i_reg(req), .o_reg_rdata(rdata),
		.i_ch_ok_live(live), .i_fuse_ok_include(fuse),
		.i_thermal_shutdown(tsd), .i_latchoff_fault(latch),
		.i_overheat(hot), .i_overheat_threshold_sel(sel),
		.i_low_supply(low), .i_channel_enable_pins(en),
		.i_pg_event_hold(hold), .i_event_mask(mask),
		.o_combined_supply_ok_out(ok), .o_int_n(int_n)
	);

	reg_host u_reg_host (.i_clk(i_clk), .i_rdata(rdata), .o_req(req));

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		u_reg_host.rd(a, d);
		chk(d, exp);
	endtask : rchk

	task automatic step(input int n);
		repeat (n) @(posedge i_clk);
	endtask : step

	task automatic final_report;
		if (n_errors == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : final_report

	// The whole sequence needs about 150 cycles
	initial begin
		#(100 * 5000);
		n_errors++;
		final_report();
	end

	// ------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------
	initial begin
		i_rst = 1'b1;
		live = 4'hF; latch = 4'h0; en = 4'hF; fuse = 1'b1; tsd = 1'b0;
		hot = 1'b0; low = 1'b0; hold = 1'b0; sel = 2'h0; mask = 6'h00;
		step(5);
		i_rst <= 1'b0;
		step(5);
		#1 chk(ok, 8'h00);
		step(10);
		#1 chk(ok, 8'h01);
		rchk(pg_fault_pkg::PG_SELECT_ADDR, 8'h0F);
		rchk(pg_fault_pkg::LIVE_PG_ADDR, 8'h0F);
		u_reg_host.wr(pg_fault_pkg::LIVE_PG_ADDR, 8'h00);
		rchk(pg_fault_pkg::LIVE_PG_ADDR, 8'h0F);
		rchk(8'h20, 8'h00);
		// Channel 3 fails while included
		live <= 4'hB;
		step(2);
		#1 chk(ok, 8'h00);
		rchk(pg_fault_pkg::LIVE_PG_ADDR, 8'h0B);
		rchk(pg_fault_pkg::EVENT_ADDR, 8'h04);
		// Excluding channel 3 lets the output qualify again
		u_reg_host.wr(pg_fault_pkg::PG_SELECT_ADDR, 8'h0B);
		step(3);
		#1 chk(ok, 8'h00);
		step(12);
		#1 chk(ok, 8'h01);
		rchk(pg_fault_pkg::PG_SELECT_ADDR, 8'h0B);
		// Failures during init or shutdown are not recorded
		hold <= 1'b1;
		live <= 4'h9;
		step(3);
		hold <= 1'b0;
		live <= 4'hF;
		rchk(pg_fault_pkg::EVENT_ADDR, 8'h04);
		// Only allowed events pull the pin
		#1 chk(int_n, 8'h01);
		step(1);
		mask <= 6'h04;
		step(3);
		#1 chk(int_n, 8'h00);
		step(1);
		mask <= 6'h20;
		step(3);
		#1 chk(int_n, 8'h01);
		step(1);
		hot <= 1'b1;
		step(3);
		rchk(pg_fault_pkg::EVENT_ADDR, 8'h04);
		sel <= 2'h1;
		step(2);
		hot <= 1'b0;
		low <= 1'b1;
		step(2);
		low <= 1'b0;
		rchk(pg_fault_pkg::EVENT_ADDR, 8'h34);
		#1 chk(int_n, 8'h00);
		u_reg_host.wr(pg_fault_pkg::EVENT_ADDR, 8'h20);
		rchk(pg_fault_pkg::EVENT_ADDR, 8'h14);
		#1 chk(int_n, 8'h01);
		step(1);
		en <= 4'h0;
		step(2);
		en <= 4'hF;
		rchk(pg_fault_pkg::EVENT_ADDR, 8'h00);
		// A clear that meets a still active level leaves the flag set
		low <= 1'b1;
		step(2);
		u_reg_host.wr(pg_fault_pkg::EVENT_ADDR, 8'h10);
		rchk(pg_fault_pkg::EVENT_ADDR, 8'h10);
		low <= 1'b0;
		u_reg_host.wr(pg_fault_pkg::EVENT_ADDR, 8'h10);
		rchk(pg_fault_pkg::EVENT_ADDR, 8'h00);
		// Latch-off flags survive clears while the fault persists
		tsd <= 1'b1;
		latch <= 4'h9;
		step(2);
		tsd <= 1'b0;
		latch <= 4'h1;
		rchk(pg_fault_pkg::LATCHOFF_ADDR, 8'h19);
		u_reg_host.wr(pg_fault_pkg::LATCHOFF_ADDR, 8'h1F);
		rchk(pg_fault_pkg::LATCHOFF_ADDR, 8'h01);
		latch <= 4'h0;
		step(1);
		u_reg_host.wr(pg_fault_pkg::LATCHOFF_ADDR, 8'h01);
		rchk(pg_fault_pkg::LATCHOFF_ADDR, 8'h00);
		// A mid-run reset reloads the select from the other fuse level
		fuse <= 1'b0;
		i_rst <= 1'b1;
		step(2);
		i_rst <= 1'b0;
		step(2);
		#1 chk(ok, 8'h00);
		chk(int_n, 8'h01);
		rchk(pg_fault_pkg::PG_SELECT_ADDR, 8'h00);
		step(10);
		#1 chk(ok, 8'h01);
		final_report();
	end
endmodule : testbench
